// ---- hw/tmrpwm_outdrv.sv ----
// Output stage: applies enable and level settings and registers the timer pins
module tmrpwm_outdrv
    import tmrpwm_pkg::*;
#(
    parameter int unsigned N_CH = 3
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Waveform and settings
    input wire logic sq_nxt_i,
    input wire logic [N_CH-1:0] pwm_nxt_i,
    input wire logic [N_CH:0] en_i,
    input wire logic [N_CH:0] lvl_i,
    // Pins
    output logic square_out_o,
    output logic [N_CH-1:0] pwm_out_k_o
);

    if (N_CH < 1 || N_CH > 3) begin : g_chk
        $error("tmrpwm_outdrv: N_CH must be 1 to 3");
    end

    typedef struct packed {
        logic sq;
        logic [N_CH-1:0] pwm;
    } tmrpwm_pin_t;

    tmrpwm_pin_t s_r;
    tmrpwm_pin_t s_nxt;
    logic [N_CH-1:0] pwm_drv;

    // Disabled channel pins rest low; enabled ones follow the polarity bit
    for (genvar k = 0; k < N_CH; k++) begin : g_ch
        assign pwm_drv[k] = en_i[k+1] ? (pwm_nxt_i[k] ^ lvl_i[k+1]) : 1'b0;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.pwm = pwm_drv;
        // Square pin shows the level bit whenever it is disabled
        s_nxt.sq = en_i[0] ? sq_nxt_i : lvl_i[0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign square_out_o = s_r.sq;
    assign pwm_out_k_o = s_r.pwm;

endmodule

// ---- hw/tmrpwm_sync.sv ----
// Three-stage synchroniser with agreement filter and edge pulses for the trigger pin
module tmrpwm_sync
    import tmrpwm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Pin and result
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic lvl;
    } tmrpwm_sync_t;

    tmrpwm_sync_t s_r;
    tmrpwm_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = pin_i;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        // A change counts only once two settled stages agree
        if (s_r.ff2 == s_r.ff3) begin
            s_nxt.lvl = s_r.ff3;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_o = s_r.lvl;
    assign rise_o = (s_r.ff2 == s_r.ff3) && s_r.ff3 && !s_r.lvl;
    assign fall_o = (s_r.ff2 == s_r.ff3) && !s_r.ff3 && s_r.lvl;

endmodule

// ---- hw/tmrpwm_top.sv ----
// Timer core: one-shot pulse and PWM modes with Avalon-MM register access
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
module tmrpwm_top
    import tmrpwm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // External trigger pin
    input wire logic ext_trig_i,
    // Timer pins
    output logic square_out_o,
    output logic [2:0] pwm_out_k_o,
    // Match events
    output logic cycle_match_irq_o,
    output logic [2:0] channel_match_irq_o
);

    tmrpwm_state_t s_r;
    tmrpwm_state_t s_nxt;

    logic trg_rise;
    logic trg_fall;
    logic ext_trig;
    logic bus_req;
    logic wr_acc;
    logic sw_trig;
    logic run;
    logic wr_cmp1;
    logic [5:0] word_addr;
    tmrpwm_outcfg_t outcfg;

    tmrpwm_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(ext_trig_i),
        .level_o(),
        .rise_o(trg_rise),
        .fall_o(trg_fall)
    );

    // Byte-lane merge for registers of up to 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        return be[0] ? wd[7:0] : old;
    endfunction

    // Register read multiplexer; unmapped words read zero
    function automatic logic [31:0] rd_mux(input tmrpwm_state_t st, input logic [5:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFS_CTL0: d = {24'h00_0000, st.ctl0};
            OFS_CTL1: d = {29'h0000_0000, st.mode};
            OFS_OUTCTL: d = {24'h00_0000, st.outctl};
            OFS_INEDGE: d = {24'h00_0000, st.inedge};
            OFS_TRGEDGE: d = {24'h00_0000, st.trgedge};
            OFS_OPT0: d = {24'h00_0000, st.opt0};
            OFS_CNT: d = {16'h0000, st.cnt};
            OFS_CMP0: d = {16'h0000, st.cmp[0]};
            OFS_CMP1: d = {16'h0000, st.cmp[1]};
            OFS_CMP2: d = {16'h0000, st.cmp[2]};
            OFS_CMP3: d = {16'h0000, st.cmp[3]};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    assign word_addr = {avs_address_i[5:2], 2'b00};
    assign bus_req = avs_read_i || avs_write_i;
    assign wr_acc = avs_write_i && !s_r.wait_r;
    assign sw_trig = wr_acc && (word_addr == OFS_CTL1) && avs_byteenable_i[0]
                     && avs_writedata_i[CTL1_SWTRIG_POS];
    assign wr_cmp1 = wr_acc && (word_addr == OFS_CMP1);
    assign run = s_r.ctl0[CTL0_RUN_POS];

    // Edge select only matters for the trigger; the input-edge and option registers
    // are plain storage here and never steer the counter
    always_comb begin
        case (s_r.trgedge[TRG_ETS_LSB +: 2])
            EDGE_RISE: ext_trig = trg_rise;
            EDGE_FALL: ext_trig = trg_fall;
            EDGE_BOTH: ext_trig = trg_rise || trg_fall;
            default: ext_trig = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.irq0 = 1'b0;
        s_nxt.irqk = 3'h0;

        // Bus: one wait cycle, then a single acknowledge cycle
        s_nxt.wait_r = !(bus_req && s_r.wait_r);
        if (bus_req && s_r.wait_r) begin
            s_nxt.rdata = rd_mux(s_r, word_addr);
        end
        if (wr_acc) begin
            case (word_addr)
                OFS_CTL0: s_nxt.ctl0 = merge8(s_r.ctl0, avs_writedata_i, avs_byteenable_i);
                OFS_CTL1: begin
                    if (avs_byteenable_i[0]) begin
                        s_nxt.mode = avs_writedata_i[2:0];
                    end
                end
                OFS_OUTCTL: begin
                    s_nxt.outctl = merge8(s_r.outctl, avs_writedata_i, avs_byteenable_i);
                end
                OFS_INEDGE: s_nxt.inedge = merge8(s_r.inedge, avs_writedata_i, avs_byteenable_i);
                OFS_TRGEDGE: begin
                    s_nxt.trgedge = merge8(s_r.trgedge, avs_writedata_i, avs_byteenable_i);
                end
                OFS_OPT0: s_nxt.opt0 = merge8(s_r.opt0, avs_writedata_i, avs_byteenable_i);
                OFS_CMP0: s_nxt.cmp[0] = merge16(s_r.cmp[0], avs_writedata_i, avs_byteenable_i);
                OFS_CMP1: s_nxt.cmp[1] = merge16(s_r.cmp[1], avs_writedata_i, avs_byteenable_i);
                OFS_CMP2: s_nxt.cmp[2] = merge16(s_r.cmp[2], avs_writedata_i, avs_byteenable_i);
                OFS_CMP3: s_nxt.cmp[3] = merge16(s_r.cmp[3], avs_writedata_i, avs_byteenable_i);
                default: s_nxt.cmp = s_r.cmp;
            endcase
        end

        // Counter sequencing
        case (s_r.cst)
            CS_IDLE: begin
                s_nxt.cnt = CNT_MAX;
                if (run && s_r.mode == MODE_PWM) begin
                    s_nxt.cst = CS_RUN;
                    s_nxt.cnt = CNT_ZERO;
                    s_nxt.wbuf = s_r.cmp;
                    s_nxt.pend = 1'b0;
                end else if (run && s_r.mode == MODE_ONESHOT) begin
                    s_nxt.cst = CS_WAIT;
                end
            end
            CS_WAIT: begin
                s_nxt.cnt = CNT_MAX;
                if (!run || s_r.mode != MODE_ONESHOT) begin
                    s_nxt.cst = CS_IDLE;
                end else if (sw_trig || ext_trig) begin
                    s_nxt.cst = CS_RUN;
                    s_nxt.cnt = CNT_ZERO;
                end
            end
            CS_RUN: begin
                if (!run || (s_r.mode != MODE_ONESHOT && s_r.mode != MODE_PWM)) begin
                    s_nxt.cst = CS_IDLE;
                    s_nxt.cnt = CNT_MAX;
                end else if (s_r.mode == MODE_ONESHOT) begin
                    // Compare values apply directly; a lowered one lets the count
                    // run through FFFF and wrap to zero before matching
                    if (s_r.cnt == s_r.cmp[0]) begin
                        s_nxt.cnt = CNT_MAX;
                        s_nxt.cst = CS_WAIT;
                        s_nxt.irq0 = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end else begin
                    // Cycle end: clear, raise the cycle event, flip the square wave
                    if (s_r.cnt == s_r.wbuf[0]) begin
                        s_nxt.cnt = CNT_ZERO;
                        s_nxt.irq0 = 1'b1;
                        s_nxt.wave.sq = !s_r.wave.sq;
                        if (s_r.pend) begin
                            s_nxt.wbuf = s_r.cmp;
                            s_nxt.pend = 1'b0;
                        end
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
            end
            default: begin
                s_nxt.cst = CS_IDLE;
                s_nxt.cnt = CNT_MAX;
            end
        endcase

        // Arming by a channel 1 write; a write in the transfer cycle is not lost
        if (wr_cmp1 && s_r.mode == MODE_PWM) begin
            s_nxt.pend = 1'b1;
        end

        // Waveforms, aligned with the count they belong to
        if (s_nxt.cst != CS_RUN) begin
            s_nxt.wave = '0;
        end else if (s_r.mode == MODE_ONESHOT) begin
            s_nxt.wave.sq = 1'b1;
            for (int k = 1; k < 4; k++) begin
                if (s_nxt.cnt == s_nxt.cmp[k]) begin
                    s_nxt.wave.pwm[k-1] = 1'b1;
                    s_nxt.irqk[k-1] = 1'b1;
                end
            end
        end else begin
            for (int k = 1; k < 4; k++) begin
                s_nxt.wave.pwm[k-1] = s_nxt.cnt < s_nxt.wbuf[k];
                s_nxt.irqk[k-1] = s_nxt.cnt == s_nxt.wbuf[k];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r.wait_r <= 1'b1;
            s_r.rdata <= 32'h0000_0000;
            s_r.ctl0 <= RST_CTL0;
            s_r.mode <= RST_CTL1[2:0];
            s_r.outctl <= RST_OUTCTL;
            s_r.inedge <= RST_EDGE;
            s_r.trgedge <= RST_EDGE;
            s_r.opt0 <= RST_OPT0;
            s_r.cmp <= {4{RST_CMP}};
            s_r.wbuf <= {4{RST_CMP}};
            s_r.pend <= 1'b0;
            s_r.cnt <= CNT_MAX;
            s_r.cst <= CS_IDLE;
            s_r.wave <= '0;
            s_r.irq0 <= 1'b0;
            s_r.irqk <= 3'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Field split: even bits enable, odd bits level
    for (genvar k = 0; k < 4; k++) begin : g_cfg
        assign outcfg.en[k] = s_r.outctl[2*k];
        assign outcfg.lvl[k] = s_r.outctl[2*k+1];
    end

    // Pins are registered alongside the count, so they share its edge
    tmrpwm_outdrv #(
        .N_CH(3)
    ) u_outdrv (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .sq_nxt_i(s_nxt.wave.sq),
        .pwm_nxt_i(s_nxt.wave.pwm),
        .en_i(outcfg.en),
        .lvl_i(outcfg.lvl),
        .square_out_o(square_out_o),
        .pwm_out_k_o(pwm_out_k_o)
    );

    assign avs_readdata_o = s_r.rdata;
    assign avs_waitrequest_o = s_r.wait_r;
    assign cycle_match_irq_o = s_r.irq0;
    assign channel_match_irq_o = s_r.irqk;

endmodule

// ---- include/tmrpwm_pkg.sv ----
// Package: register map, field layout, reset values and carrier types of the timer PWM block
package tmrpwm_pkg;

    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // Register byte offsets
    localparam logic [5:0] OFS_CTL0 = 6'h00;
    localparam logic [5:0] OFS_CTL1 = 6'h04;
    localparam logic [5:0] OFS_OUTCTL = 6'h08;
    localparam logic [5:0] OFS_INEDGE = 6'h0c;
    localparam logic [5:0] OFS_TRGEDGE = 6'h10;
    localparam logic [5:0] OFS_OPT0 = 6'h14;
    localparam logic [5:0] OFS_CNT = 6'h18;
    localparam logic [5:0] OFS_CMP0 = 6'h1c;
    localparam logic [5:0] OFS_CMP1 = 6'h20;
    localparam logic [5:0] OFS_CMP2 = 6'h24;
    localparam logic [5:0] OFS_CMP3 = 6'h28;

    // Field positions
    localparam int unsigned CTL0_RUN_POS = 7;
    localparam int unsigned CTL1_SWTRIG_POS = 6;
    localparam int unsigned TRG_ETS_LSB = 0;

    // Operating mode codes
    localparam logic [2:0] MODE_ONESHOT = 3'h3;
    localparam logic [2:0] MODE_PWM = 3'h4;

    // Trigger edge codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Reset values
    localparam logic [7:0] RST_CTL0 = 8'h00;
    localparam logic [7:0] RST_CTL1 = 8'h00;
    localparam logic [7:0] RST_OUTCTL = 8'h00;
    localparam logic [7:0] RST_EDGE = 8'h00;
    localparam logic [7:0] RST_OPT0 = 8'h00;
    localparam logic [15:0] RST_CMP = 16'h0000;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT = 2'b01,
        CS_RUN = 2'b10
    } tmrpwm_cstate_t;

    // Output control: bit 2k is enable, bit 2k+1 is level
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] en;
    } tmrpwm_outcfg_t;

    // Raw waveform before enable and polarity
    typedef struct packed {
        logic [2:0] pwm;
        logic sq;
    } tmrpwm_wave_t;

    typedef struct packed {
        logic wait_r;
        logic [31:0] rdata;
        logic [7:0] ctl0;
        logic [2:0] mode;
        logic [7:0] outctl;
        logic [7:0] inedge;
        logic [7:0] trgedge;
        logic [7:0] opt0;
        logic [3:0][15:0] cmp;
        logic [3:0][15:0] wbuf;
        logic pend;
        logic [15:0] cnt;
        tmrpwm_cstate_t cst;
        tmrpwm_wave_t wave;
        logic irq0;
        logic [2:0] irqk;
    } tmrpwm_state_t;

endpackage

// ---- test/tb_top.sv ----
// Testbench: register access, PWM and one-shot scenarios for the timer block
module tb_top
    import tmrpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, square_out_o, cycle_match_irq_o, ext_trig;
    logic fire = 1'b0;
    logic [2:0] pwm_out_k_o, channel_match_irq_o;
    logic [15:0] per;
    logic [2:0][15:0] hi;
    logic [15:0] rq[$];
    int err_total = 0;
    int num_checks = 0;

    tmrpwm_top DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_trig_i(ext_trig),
        .square_out_o(square_out_o), .pwm_out_k_o(pwm_out_k_o),
        .cycle_match_irq_o(cycle_match_irq_o), .channel_match_irq_o(channel_match_irq_o));
    tmrpwm_load u_load (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pwm_i(pwm_out_k_o),
        .cyc_irq_i(cycle_match_irq_o), .fire_i(fire), .ext_trig_o(ext_trig), .per_o(per),
        .hi_o(hi));

    initial forever #25 core_clk_i = ~core_clk_i;

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        err_total++;
        $display("[FAIL] %s expected answer seen timeout", nm);
        complete_run();
    endtask
    // Request held until the rising edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {16'h0000, d};
        do begin
            @(posedge core_clk_i);
            n++;
            if (n > 40) hang("bus answer");
        end while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rq.push_back(e);
        xfer(1'b0, a, 16'h0000);
    endtask
    task automatic wait_cyc(input int k);
        int n;
        n = 0;
        repeat (k) begin
            do begin
                @(negedge core_clk_i);
                n++;
                if (n > 70000) hang("cycle event");
            end while (cycle_match_irq_o !== 1'b1);
        end
        @(posedge core_clk_i);
    endtask
    task automatic meas(input logic [15:0] p, w1, w2, w3);
        @(negedge core_clk_i);
        chk("period", p, per);
        chk("width 1", w1, hi[0]);
        chk("width 2", w2, hi[1]);
        chk("width 3", w3, hi[2]);
        @(posedge core_clk_i);
    endtask

    always @(posedge core_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && rq.size() > 0) begin
            chk("read data", rq.pop_front(), avs_readdata_o[15:0]);
        end
    end

    initial begin
        logic [15:0] v;
        logic [15:0] w1;
        time t0;
        void'($urandom(32'hd43b));
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        rd(OFS_CNT, CNT_MAX);
        rd(OFS_OUTCTL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom());
            wr(OFS_CMP0 + 6'(4 * i), v);
            rd(OFS_CMP0 + 6'(4 * i), v);
        end
        wr(6'h3c, 16'h1234);
        rd(6'h3c, 16'h0000);
        $display("Test registers done");
        w1 = 16'($urandom_range(1, 5));
        wr(OFS_CMP0, 16'h0007);
        wr(OFS_CMP1, w1);
        wr(OFS_CMP2, 16'h0005);
        wr(OFS_CMP3, 16'h0008);
        wr(OFS_OUTCTL, 16'h0055);
        wr(OFS_CTL1, 16'(MODE_PWM));
        wr(OFS_CTL0, 16'h0080);
        wait_cyc(3);
        meas(16'd8, w1, 16'd5, 16'd8);
        wr(OFS_CMP0, 16'h0005);
        wr(OFS_CMP2, 16'h0003);
        wait_cyc(2);
        meas(16'd8, w1, 16'd5, 16'd8);
        wr(OFS_CMP1, w1);
        wait_cyc(2);
        meas(16'd6, w1, 16'd3, 16'd6);
        wr(OFS_INEDGE, 16'($urandom_range(0, 255)));
        wr(OFS_OPT0, 16'($urandom_range(0, 255)));
        wr(OFS_OUTCTL, 16'h005d);
        wait_cyc(2);
        meas(16'd6, 16'd6 - w1, 16'd3, 16'd6);
        $display("Test pwm done");
        wr(OFS_CTL0, 16'h0000);
        wr(OFS_OUTCTL, 16'h005e);
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk("stopped pins", 16'h0001, {13'h0000, pwm_out_k_o});
        chk("square idle", 16'h0001, {15'h0000, square_out_o});
        @(posedge core_clk_i);
        wr(OFS_OUTCTL, 16'h0055);
        wr(OFS_CMP0, 16'd20);
        wr(OFS_CMP1, 16'd5);
        wr(OFS_TRGEDGE, 16'($urandom_range(1, 3)));
        wr(OFS_CTL1, 16'(MODE_ONESHOT));
        wr(OFS_CTL0, 16'h0080);
        fire <= 1'b1;
        @(posedge core_clk_i);
        fire <= 1'b0;
        wait_cyc(1);
        wr(OFS_CMP0, 16'd20);
        wr(OFS_CTL1, 16'h0043);
        wait_cyc(1);
        @(negedge core_clk_i);
        chk("pulse width", 16'd16, hi[0]);
        @(posedge core_clk_i);
        rd(OFS_CNT, CNT_MAX);
        wr(OFS_CTL1, 16'h0043);
        repeat (12) @(posedge core_clk_i);
        t0 = $time;
        wr(OFS_CMP0, 16'h0003);
        wait_cyc(1);
        chk("wrap length", 16'h0001, {15'h0000, ($time - t0) > 64'd3200000});
        rd(OFS_CNT, CNT_MAX);
        $display("Test one-shot done");
        complete_run();
    end
endmodule

// ---- test/tmrpwm_asserts.sv ----
// Checker: port-level timing of bus, pins and match events of the timer block
module tmrpwm_asserts
    import tmrpwm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins and events
    input wire logic ext_trig_i,
    input wire logic square_out_o,
    input wire logic [2:0] pwm_out_k_o,
    input wire logic cycle_match_irq_o,
    input wire logic [2:0] channel_match_irq_o
);
    logic [2:0] mode_r;
    logic run_r;
    logic [7:0] oc_r;
    logic wl;
    logic pwm_m;
    logic os_m;
    logic [2:0] inact;
    assign wl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign pwm_m = run_r && mode_r == MODE_PWM;
    assign os_m = run_r && mode_r == MODE_ONESHOT;
    assign inact = {oc_r[7] & oc_r[6], oc_r[5] & oc_r[4], oc_r[3] & oc_r[2]};
    // Shadow of the control fields, taken at the edge where a write lands
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= 3'h0;
            run_r <= 1'b0;
            oc_r <= 8'h00;
        end else if (wl) begin
            if (avs_address_i == OFS_CTL0) run_r <= avs_writedata_i[CTL0_RUN_POS];
            if (avs_address_i == OFS_CTL1) mode_r <= avs_writedata_i[2:0];
            if (avs_address_i == OFS_OUTCTL) oc_r <= avs_writedata_i[7:0];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    ack_one_cycle_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    square_toggle_a: assert property (pwm_m && oc_r[0] && $stable(oc_r) && cycle_match_irq_o
        |-> square_out_o != $past(square_out_o))
        else $error("square output did not toggle at cycle event");
    square_idle_a: assert property (!oc_r[0] ##1 $stable(oc_r) |-> square_out_o == oc_r[1])
        else $error("disabled square output not at its set level");
    channel_off_a: assert property (!oc_r[2] ##1 $stable(oc_r) |-> !pwm_out_k_o[0])
        else $error("disabled channel output not low");
    pwm_fall_a: assert property (pwm_m && $stable(oc_r) && oc_r[3:2] == 2'b01
        && $fell(pwm_out_k_o[0]) |-> channel_match_irq_o[0])
        else $error("pwm output ended without channel event");
    pulse_set_a: assert property (os_m && $stable(oc_r) && oc_r[3:2] == 2'b01
        && channel_match_irq_o[0] |-> pwm_out_k_o[0])
        else $error("pulse output not active at channel event");
    pulse_end_a: assert property (os_m && $stable(oc_r) && oc_r[3:2] == 2'b01
        && cycle_match_irq_o |-> !pwm_out_k_o[0])
        else $error("pulse output still active at cycle event");
    stop_idle_a: assert property ((!run_r && $stable(oc_r)) [*3] |-> !cycle_match_irq_o
        && channel_match_irq_o == 3'h0 && pwm_out_k_o == inact)
        else $error("stopped timer not idle");
    cover property (pwm_m && cycle_match_irq_o);
    cover property (os_m && channel_match_irq_o[0]);
    cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind tmrpwm_top tmrpwm_asserts u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_trig_i(ext_trig_i),
    .square_out_o(square_out_o), .pwm_out_k_o(pwm_out_k_o),
    .cycle_match_irq_o(cycle_match_irq_o), .channel_match_irq_o(channel_match_irq_o)
);

// ---- test/tmrpwm_load.sv ----
// Pin load model: times the outputs over each cycle and drives the trigger pin
module tmrpwm_load
    import tmrpwm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Block pins
    input wire logic [2:0] pwm_i,
    input wire logic cyc_irq_i,
    input wire logic fire_i,
    // Trigger pin and readings
    output logic ext_trig_o,
    output logic [15:0] per_o,
    output logic [2:0][15:0] hi_o
);
    logic [15:0] per_r;
    logic [2:0][15:0] hi_r;
    logic [7:0] trig_r;
    // Trigger held eight cycles so that it outlasts the input filter
    assign ext_trig_o = |trig_r;
    // Readings latch at each cycle event, so each spans exactly one cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_r <= 16'h0000;
            hi_r <= '0;
            per_o <= 16'h0000;
            hi_o <= '0;
            trig_r <= 8'h00;
        end else begin
            trig_r <= fire_i ? 8'hff : (trig_r >> 1);
            per_r <= cyc_irq_i ? 16'h0001 : per_r + 16'h0001;
            for (int k = 0; k < 3; k++) begin
                hi_r[k] <= (cyc_irq_i ? 16'h0000 : hi_r[k]) + {15'h0000, pwm_i[k]};
            end
            if (cyc_irq_i) begin
                per_o <= per_r;
                hi_o <= hi_r;
            end
        end
    end
endmodule
